// file: design/config_lut_pkg.sv
// Constants for the configuration word and the coefficient table address map.
// Assumes a single 100 MHz device clock; no bus, loads come from command logic.
// Summary of operation
// R1: Trim bits 15:13 preserved by software rewrites
// R2: Bit 12 selects external resistors
// R3: Bit 11 enables clock output driver
// R4: Bit 10 swaps sensor input polarity
// R5: Bit 9 gives coarse offset sign
// R6: Bits 8:6 coarse magnitude, zero means none
// R7: Bits 5:2 sixteen-step gain code
// R8: Bit 1 gives offset DAC sign
// R9: Bit 0 gives offset TC DAC sign
// R10: Low indices: offset bytes at twice index
// R11: Low indices: span bytes at 200h plus twice
// R12: Indices 80h-AFh map to 100h-15Fh, 1A0h-1FFh
// R13: Temperature index is rising 8-bit value
// R14: Trim code picks one of eight frequencies
// R15: Load command writes holding value when selected
// R16: Index above AFh keeps last valid addresses
package config_lut_pkg;
	localparam int CFG_W = 16;
	localparam int EE_ADDR_W = 10;
	localparam int INDEX_W = 8;
	localparam int CAL_SEL_W = 4;
	// Configuration word field positions
	localparam int OSC_MSB = 15;
	localparam int OSC_LSB = 13;
	localparam int EXTERNAL_RESISTOR_SELECT_BIT = 12;
	localparam int CLKOUT_BIT = 11;
	localparam int SWAP_BIT = 10;
	localparam int COARSE_OFFSET_SIGN_BIT = 9;
	localparam int IRO_MSB = 8;
	localparam int IRO_LSB = 6;
	localparam int GAIN_MSB = 5;
	localparam int GAIN_LSB = 2;
	localparam int OFFSET_DAC_SIGN_BIT = 1;
	localparam int OTC_SIGN_BIT = 0;
	// Reset value: trim at the nominal-frequency code, everything else clear
	localparam logic [15:0] CONFIG_RESET = 16'h8000;
	// Calibration register select code of the configuration word
	localparam logic [3:0] CAL_SEL_CONFIG = 4'h0;
	// Table map
	localparam logic [7:0] INDEX_LOW_LAST = 8'h7f;
	localparam logic [7:0] INDEX_HIGH_LAST = 8'haf;
	localparam logic [9:0] SPAN_LOW_BASE = 10'h200;
	localparam logic [9:0] SPAN_HIGH_BASE = 10'h1a0;
	localparam logic [9:0] OFFSET_HIGH_BASE = 10'h100;
	localparam logic [7:0] INDEX_HIGH_FIRST = 8'h80;
endpackage

// file: design/config_word_and_lut_addressing.sv
// Configuration word register, its field decode, and coefficient address lookup.
// Assumes load commands and the temperature index come from logic on clock_in.
`timescale 1ns/10ps
`default_nettype none
module config_word_and_lut_addressing
#(
	parameter int EE_ADDR_BITS = config_lut_pkg::EE_ADDR_W
)
(
	// Clock and reset
	input wire logic clock_in,
	input wire logic srst_in,
	// Calibration register load
	input wire logic load_cal_register_cmd_in,
	input wire logic [config_lut_pkg::CAL_SEL_W-1:0] cal_register_select_in,
	input wire logic [config_lut_pkg::CFG_W-1:0] data_hold_in,
	// Temperature index
	input wire logic [config_lut_pkg::INDEX_W-1:0] temp_index_in,
	// Configuration word and decoded controls
	output logic [config_lut_pkg::CFG_W-1:0] configuration_word_out,
	output logic [2:0] osc_trim_code_out,
	output logic external_resistor_select_out,
	output logic clock_out_driver_enable_out,
	output logic input_polarity_swap_out,
	output logic coarse_offset_sign_out,
	output logic [2:0] coarse_offset_magnitude_out,
	output logic signed [3:0] coarse_offset_step_out,
	output logic [3:0] gain_code_out,
	output logic offset_dac_sign_out,
	output logic offset_tc_dac_sign_out,
	// Coefficient table addresses
	output logic [EE_ADDR_BITS-1:0] offset_lo_addr_out,
	output logic [EE_ADDR_BITS-1:0] offset_hi_addr_out,
	output logic [EE_ADDR_BITS-1:0] span_lo_addr_out,
	output logic [EE_ADDR_BITS-1:0] span_hi_addr_out,
	output logic lut_addr_valid_out
);
	import config_lut_pkg::*;

	// The mapper builds 10-bit byte addresses; any other width is refused
	if (EE_ADDR_BITS != EE_ADDR_W)
	begin : g_addr_width_check
		$error("EE_ADDR_BITS must be 10");
	end

	logic [15:0] config_r;
	logic load_config;
	lut_addr_if lut ();

	assign load_config = load_cal_register_cmd_in && (cal_register_select_in == CAL_SEL_CONFIG);

	// Whole word is written; keeping the trim bits is up to the writer
	always_ff @(posedge clock_in)
	begin
		if (srst_in)
			config_r <= CONFIG_RESET;
		else if (load_config)
			config_r <= data_hold_in; // see R15, see R1
	end

	assign configuration_word_out = config_r;

	// Field decode, one register stage behind the word
	always_ff @(posedge clock_in)
	begin
		if (srst_in)
		begin
			osc_trim_code_out <= CONFIG_RESET[OSC_MSB:OSC_LSB];
		end
		else
		begin
			osc_trim_code_out <= config_r[OSC_MSB:OSC_LSB]; // see R14
		end
	end

	// Sensor routing: resistor source, clock driver, input polarity
	always_ff @(posedge clock_in)
	begin
		if (srst_in)
		begin
			external_resistor_select_out <= CONFIG_RESET[EXTERNAL_RESISTOR_SELECT_BIT];
			clock_out_driver_enable_out <= CONFIG_RESET[CLKOUT_BIT];
			input_polarity_swap_out <= CONFIG_RESET[SWAP_BIT];
		end
		else
		begin
			external_resistor_select_out <= config_r[EXTERNAL_RESISTOR_SELECT_BIT]; // see R2
			clock_out_driver_enable_out <= config_r[CLKOUT_BIT]; // see R3
			input_polarity_swap_out <= config_r[SWAP_BIT]; // see R4
		end
	end

	// Coarse offset: sign, magnitude and the signed step built from them
	always_ff @(posedge clock_in)
	begin
		if (srst_in)
		begin
			coarse_offset_sign_out <= CONFIG_RESET[COARSE_OFFSET_SIGN_BIT];
			coarse_offset_magnitude_out <= CONFIG_RESET[IRO_MSB:IRO_LSB];
			coarse_offset_step_out <= 4'sh0;
		end
		else
		begin
			coarse_offset_sign_out <= config_r[COARSE_OFFSET_SIGN_BIT]; // see R5
			coarse_offset_magnitude_out <= config_r[IRO_MSB:IRO_LSB]; // see R6
			// Signed step: zero magnitude gives zero for either sign
			coarse_offset_step_out <= config_r[COARSE_OFFSET_SIGN_BIT] ? $signed({1'b0, config_r[IRO_MSB:IRO_LSB]})
				: -$signed({1'b0, config_r[IRO_MSB:IRO_LSB]}); // see R5, see R6
		end
	end

	// Gain code and DAC signs
	always_ff @(posedge clock_in)
	begin
		if (srst_in)
		begin
			gain_code_out <= CONFIG_RESET[GAIN_MSB:GAIN_LSB];
			offset_dac_sign_out <= CONFIG_RESET[OFFSET_DAC_SIGN_BIT];
			offset_tc_dac_sign_out <= CONFIG_RESET[OTC_SIGN_BIT];
		end
		else
		begin
			gain_code_out <= config_r[GAIN_MSB:GAIN_LSB]; // see R7
			offset_dac_sign_out <= config_r[OFFSET_DAC_SIGN_BIT]; // see R8
			offset_tc_dac_sign_out <= config_r[OTC_SIGN_BIT]; // see R9
		end
	end

	// Index is taken as an unsigned 8-bit value rising with temperature
	assign lut.index = temp_index_in; // see R13

	lut_addr_map u_map
	(
		.clock_in(clock_in),
		.srst_in(srst_in),
		.lut(lut.mapper)
	);

	assign offset_lo_addr_out = lut.offset_lo;
	assign offset_hi_addr_out = lut.offset_hi;
	assign span_lo_addr_out = lut.span_lo;
	assign span_hi_addr_out = lut.span_hi;
	assign lut_addr_valid_out = lut.valid;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (srst_in);

	sequence load_seq;
		load_cal_register_cmd_in && cal_register_select_in == 4'h0;
	endsequence

	sequence other_seq;
		!(load_cal_register_cmd_in && cal_register_select_in == 4'h0);
	endsequence

	// A load reaches the decoded outputs one edge after it reaches the word
	sequence load_settled_seq;
		load_seq ##1 1'b1;
	endsequence

	sequence quiet_seq;
		other_seq ##1 other_seq;
	endsequence

	sequence index_defined_seq;
		temp_index_in <= 8'haf;
	endsequence

	sequence index_undefined_seq;
		temp_index_in > 8'haf;
	endsequence

	config_load_a: assert property (load_seq |=> configuration_word_out == $past(data_hold_in)) // see R15
		else $error("configuration word not loaded");
	config_hold_a: assert property (other_seq |=> $stable(configuration_word_out)) // see R15
		else $error("configuration word changed without load");
	resistor_select_a: assert property (load_settled_seq // see R2
		|=> external_resistor_select_out == $past(data_hold_in[12], 2))
		else $error("resistor select does not follow bit 12");
	clock_driver_a: assert property (load_settled_seq // see R3
		|=> clock_out_driver_enable_out == $past(data_hold_in[11], 2))
		else $error("clock driver enable does not follow bit 11");
	polarity_swap_a: assert property (##1 input_polarity_swap_out == $past(configuration_word_out[10])) // see R4
		else $error("polarity swap does not follow bit 10");
	coarse_sign_a: assert property (##1 coarse_offset_sign_out == $past(configuration_word_out[9])) // see R5
		else $error("coarse offset sign does not follow bit 9");
	coarse_mag_a: assert property (##1 coarse_offset_magnitude_out // see R6
		== $past(configuration_word_out[8:6]))
		else $error("coarse offset magnitude does not follow bits 8:6");
	offset_step_a: assert property (##1 (($past(configuration_word_out[8:6]) == 3'h0) // see R5, see R6
		? coarse_offset_step_out == 4'sh0 : (coarse_offset_step_out > 4'sh0) == $past(configuration_word_out[9])))
		else $error("coarse offset step wrong");
	step_positive_a: assert property (coarse_offset_sign_out // see R5, see R6
		|-> coarse_offset_step_out == $signed({1'b0, coarse_offset_magnitude_out}))
		else $error("positive coarse step wrong");
	step_negative_a: assert property (!coarse_offset_sign_out // see R5, see R6
		|-> coarse_offset_step_out == -$signed({1'b0, coarse_offset_magnitude_out}))
		else $error("negative coarse step wrong");
	gain_code_a: assert property (##1 gain_code_out == $past(configuration_word_out[5:2])) // see R7
		else $error("gain code does not follow bits 5:2");
	dac_signs_a: assert property (##1 offset_dac_sign_out == $past(configuration_word_out[1]) // see R8, see R9
		&& offset_tc_dac_sign_out == $past(configuration_word_out[0]))
		else $error("DAC sign bits wrong");
	trim_code_a: assert property (##1 osc_trim_code_out == $past(configuration_word_out[15:13])) // see R14
		else $error("trim code does not follow bits 15:13");
	decode_quiet_a: assert property (quiet_seq |=> $stable(gain_code_out) // see R7, see R2, see R3
		&& $stable(coarse_offset_step_out) && $stable(external_resistor_select_out)
		&& $stable(clock_out_driver_enable_out))
		else $error("decoded outputs moved without a load");

	valid_range_a: assert property (index_defined_seq |=> lut_addr_valid_out) // see R12
		else $error("valid low for a defined index");
	offset_window_a: assert property (lut_addr_valid_out |-> offset_hi_addr_out <= 10'h15f) // see R10, see R12
		else $error("offset address outside its table");
	span_window_a: assert property (lut_addr_valid_out // see R11, see R12
		|-> span_lo_addr_out >= 10'h1a0 && span_hi_addr_out <= 10'h2ff)
		else $error("span address outside its table");
	undefined_hold_a: assert property (index_undefined_seq |=> !lut_addr_valid_out // see R16
		&& $stable(offset_hi_addr_out) && $stable(span_hi_addr_out))
		else $error("addresses moved on an undefined index");
	reset_word_a: assert property (disable iff (1'b0) srst_in // see R14
		|=> configuration_word_out == CONFIG_RESET)
		else $error("configuration word not at reset value");
	reset_lut_a: assert property (disable iff (1'b0) srst_in // see R16
		|=> !lut_addr_valid_out && offset_lo_addr_out == 10'h000 && span_lo_addr_out == 10'h200)
		else $error("lookup addresses not at reset value");
endmodule // config_word_and_lut_addressing
`default_nettype wire

// file: design/lut_addr_if.sv
// Carries the temperature index to the table address mapper and the addresses back.
// Both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface lut_addr_if;
	logic [7:0] index;
	logic [9:0] offset_lo;
	logic [9:0] offset_hi;
	logic [9:0] span_lo;
	logic [9:0] span_hi;
	logic valid;
	modport mapper
	(
		input index,
		output offset_lo, offset_hi, span_lo, span_hi, valid
	);
	modport user
	(
		output index,
		input offset_lo, offset_hi, span_lo, span_hi, valid
	);
endinterface
`default_nettype wire

// file: design/lut_addr_map.sv
// Maps the temperature index to coefficient byte addresses, registered.
// Assumes the index comes from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module lut_addr_map
(
	// Clock and reset
	input wire logic clock_in,
	input wire logic srst_in,
	// Index in, addresses out
	lut_addr_if.mapper lut
);
	import config_lut_pkg::*;

	logic [9:0] twice;
	logic in_low;
	logic in_high;

	assign twice = {1'b0, lut.index, 1'b0};
	assign in_low = (lut.index <= INDEX_LOW_LAST);
	assign in_high = (lut.index >= INDEX_HIGH_FIRST) && (lut.index <= INDEX_HIGH_LAST);

	always_ff @(posedge clock_in)
	begin
		if (srst_in)
		begin
			lut.offset_lo <= 10'h000;
			lut.offset_hi <= 10'h001;
			lut.span_lo <= SPAN_LOW_BASE;
			lut.span_hi <= SPAN_LOW_BASE + 10'h001;
			lut.valid <= 1'b0;
		end
		else if (in_low)
		begin
			lut.offset_lo <= twice; // see R10
			lut.offset_hi <= twice + 10'h001; // see R10
			lut.span_lo <= SPAN_LOW_BASE + twice; // see R11
			lut.span_hi <= SPAN_LOW_BASE + twice + 10'h001; // see R11
			lut.valid <= 1'b1;
		end
		else if (in_high)
		begin
			// Twice the index already lands at the high offset block
			lut.offset_lo <= twice; // see R12
			lut.offset_hi <= twice + 10'h001; // see R12
			lut.span_lo <= SPAN_HIGH_BASE + (twice - OFFSET_HIGH_BASE); // see R12
			lut.span_hi <= SPAN_HIGH_BASE + (twice - OFFSET_HIGH_BASE) + 10'h001; // see R12
			lut.valid <= 1'b1;
		end
		else
		begin
			// Undefined index: addresses keep the last valid entry
			lut.valid <= 1'b0; // see R16
		end
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (srst_in);

	offset_addr_a: assert property ((lut.index <= 8'haf) // see R10, see R12
		|=> lut.offset_lo == {1'b0, $past(lut.index), 1'b0} && lut.offset_hi == lut.offset_lo + 10'h001)
		else $error("offset address mismatch");
	span_low_a: assert property ((lut.index <= 8'h7f) // see R11
		|=> lut.span_lo == 10'h200 + {1'b0, $past(lut.index), 1'b0} && lut.span_hi == lut.span_lo + 10'h001)
		else $error("low span address mismatch");
	span_high_a: assert property ((lut.index >= 8'h80 && lut.index <= 8'haf) // see R12
		|=> lut.span_lo == {1'b0, $past(lut.index), 1'b0} + 10'h0a0 && lut.span_lo[0] == 1'b0)
		else $error("high span address mismatch");
	hold_last_a: assert property ((lut.index > 8'haf) // see R16
		|=> !lut.valid && $stable(lut.offset_lo) && $stable(lut.span_lo))
		else $error("addresses moved on undefined index");
endmodule // lut_addr_map
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the configuration word register and coefficient address lookup.
// Assumes the design package is compiled first; inputs change on the falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module tb;
	import config_lut_pkg::*;
	logic clock_in;
	logic srst_in;
	logic ld;
	logic [3:0] sel;
	logic [15:0] dh;
	logic [7:0] idx;
	logic [15:0] word;
	logic [2:0] osc;
	logic external_resistor_select, clk_en, swap, c_sign, od_sign, otc_sign, valid;
	logic [2:0] c_mag;
	logic signed [3:0] c_step;
	logic [3:0] gain;
	logic [9:0] ol, oh, sl, sh;
	logic [9:0] exp_o, exp_s;
	int error_cnt = 0;
	int n_tests = 0;
	logic [7:0] idx_tab [10] = '{8'h00, 8'h05, 8'h7f, 8'h80, 8'h14, 8'h86, 8'haf, 8'hb0, 8'hff, 8'h41};
	config_word_and_lut_addressing u_dut
	(
		.clock_in(clock_in), .srst_in(srst_in), .load_cal_register_cmd_in(ld), .cal_register_select_in(sel),
		.data_hold_in(dh), .temp_index_in(idx), .configuration_word_out(word), .osc_trim_code_out(osc),
		.external_resistor_select_out(external_resistor_select), .clock_out_driver_enable_out(clk_en), .input_polarity_swap_out(swap),
		.coarse_offset_sign_out(c_sign), .coarse_offset_magnitude_out(c_mag), .coarse_offset_step_out(c_step),
		.gain_code_out(gain), .offset_dac_sign_out(od_sign), .offset_tc_dac_sign_out(otc_sign),
		.offset_lo_addr_out(ol), .offset_hi_addr_out(oh), .span_lo_addr_out(sl), .span_hi_addr_out(sh),
		.lut_addr_valid_out(valid)
	);
	initial
	begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		if (error_cnt == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic load(input logic [3:0] s, input logic [15:0] d);
		@(negedge clock_in);
		ld = 1'b1;
		sel = s;
		dh = d;
		@(negedge clock_in);
		ld = 1'b0;
	endtask
	// Decoded outputs settle one cycle after the load edge
	task automatic chk_word(input logic [15:0] d);
		logic signed [3:0] st;
		st = (d[8:6] == 3'h0) ? 4'sh0 : (d[9] ? $signed({1'b0, d[8:6]}) : -$signed({1'b0, d[8:6]}));
		repeat (2) @(negedge clock_in);
		chk(64'(word), 64'(d));
		chk(64'(osc), 64'(d[15:13]));
		chk(64'(external_resistor_select), 64'(d[12]));
		chk(64'(clk_en), 64'(d[11]));
		chk(64'(swap), 64'(d[10]));
		chk(64'(c_sign), 64'(d[9]));
		chk(64'(c_mag), 64'(d[8:6]));
		chk({60'h0, c_step}, {60'h0, st});
		chk(64'(gain), 64'(d[5:2]));
		chk(64'(od_sign), 64'(d[1]));
		chk(64'(otc_sign), 64'(d[0]));
	endtask
	task automatic chk_idx(input logic [7:0] i);
		@(negedge clock_in);
		idx = i;
		if (i <= 8'h7f)
		begin
			exp_o = {1'b0, i, 1'b0};
			exp_s = 10'h200 + {1'b0, i, 1'b0};
		end
		else if (i <= 8'haf)
		begin
			exp_o = 10'h100 + {1'b0, i - 8'h80, 1'b0};
			exp_s = 10'h1a0 + {1'b0, i - 8'h80, 1'b0};
		end
		@(negedge clock_in);
		chk(64'(valid), 64'(i <= 8'haf));
		chk({44'h0, ol, oh}, {44'h0, exp_o, exp_o + 10'h1});
		chk({44'h0, sl, sh}, {44'h0, exp_s, exp_s + 10'h1});
	endtask
	initial
	begin
		repeat (3000) @(posedge clock_in);
		error_cnt++;
		wrap_up();
	end
	initial
	begin
		srst_in = 1'b1;
		ld = 1'b0;
		sel = 4'h0;
		dh = 16'h0000;
		idx = 8'h00;
		exp_o = 10'h000;
		exp_s = 10'h200;
		repeat (16) @(negedge clock_in);
		srst_in = 1'b0;
		chk(64'(word), 64'(CONFIG_RESET));
		chk(64'(valid), 64'h0);
		chk({24'h0, ol, oh, sl, sh}, {24'h0, 10'h000, 10'h001, 10'h200, 10'h201});
		// Decoded outputs show the reset word before any load
		chk_word(CONFIG_RESET);
		// Sweep every sign and magnitude pairing and every gain code; trim bits are written back unchanged
		for (int k = 0; k < 16; k++)
		begin
			dh = {CONFIG_RESET[OSC_MSB:OSC_LSB], k[0], k[1], k[2], k[3], k[2:0], k[3:0], k[0], k[1]};
			load(4'h0, dh);
			chk_word(dh);
		end
		load(4'h0, 16'h85a6);
		// Loads aimed at other calibration registers leave the word alone
		for (int s = 1; s < 16; s++)
			load(s[3:0], 16'h5a59);
		chk_word(16'h85a6);
		// Back-to-back loads: the later one wins
		@(negedge clock_in);
		ld = 1'b1;
		sel = CAL_SEL_CONFIG;
		dh = 16'h9234;
		@(negedge clock_in);
		dh = 16'h8e9b;
		@(negedge clock_in);
		ld = 1'b0;
		chk_word(16'h8e9b);
		for (int j = 0; j < 10; j++)
			chk_idx(idx_tab[j]);
		wrap_up();
	end
endmodule // tb
`default_nettype wire
